// ==== hw/srcs_sequencer.sv ====
// Reset and bus-clock sequencer of the system integration unit, with its APB registers.
// Assumes pclk is the buffered oscillator clock; reset requests are asynchronous levels/pulses.
//
// Local design decision: register access over APB.
`default_nettype none
module srcs_sequencer
	import srcs_pkg::*;
#(
	parameter int STARTUP_LEN = STARTUP_CYCLES
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        pll_out_clock,
	input  wire logic        clock_gen_output,
	input  wire srcs_req_t   reset_req,
	input  wire logic        break_stop_wait_set,
	input  wire logic        reset_pin_in,
	output logic             reset_pin_out,
	output logic             reset_pin_oe,
	output logic             internal_reset,
	output logic [15:0]      reset_vector,
	output logic             internal_bus_clocks,
	output logic             cpu_clock_en,
	output logic             periph_clock_en,
	output logic [PRESCALER_WIDTH-1:0] prescaler,
	output logic             break_flag_clear_enable
);

	// ==========================================================
	// Parameter check
	if (STARTUP_LEN < 1 || STARTUP_LEN > 65535)
	begin : g_bad_len
		$error("STARTUP_LEN out of range");
	end

	localparam logic [15:0] START_LAST = 16'(STARTUP_LEN - 1);
	localparam logic [15:0] DRIVE_LAST = 16'(PIN_DRIVE_CYCLES - 1);
	localparam logic [15:0] HOLD_LAST  = 16'(INTERNAL_RESET_HOLD_CYCLES - 1);
	localparam logic [15:0] PIN_LAST   = 16'(PIN_FLAG_CYCLES - 1);
	localparam logic [15:0] PORLVI_PIN = 16'(STARTUP_LEN + PORLVI_PIN_CYCLES - STARTUP_CYCLES - 1);

	// ==========================================================
	// Synchronisers for asynchronous inputs
	logic [4:0] req_s1_ff;
	logic [4:0] req_s2_ff;
	logic       pin_s1_ff;
	logic       pin_s2_ff;
	logic       bsw_s1_ff;
	logic       bsw_s2_ff;

	// sync
	// Watchdog and other requests pass two flops before use.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			req_s1_ff <= 5'h0;
			req_s2_ff <= 5'h0;
		end
		else
		begin
			req_s1_ff <= reset_req;
			req_s2_ff <= req_s1_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_s1_ff <= 1'b1;
			pin_s2_ff <= 1'b1;
			bsw_s1_ff <= 1'b0;
			bsw_s2_ff <= 1'b0;
		end
		else
		begin
			pin_s1_ff <= reset_pin_in;
			pin_s2_ff <= pin_s1_ff;
			bsw_s1_ff <= break_stop_wait_set;
			bsw_s2_ff <= bsw_s1_ff;
		end
	end

	srcs_req_t req_s;
	assign req_s = req_s2_ff;

	logic por_lvi;
	logic int_src;
	assign por_lvi = req_s.power_on | req_s.low_voltage;
	assign int_src = por_lvi | req_s.watchdog | req_s.bad_opcode | req_s.bad_fetch;

	// ==========================================================
	// Reset sequencing state machine
	srcs_state_t state_ff;
	srcs_state_t nxt_state;
	logic [15:0] seq_cnt_ff;
	logic [15:0] nxt_seq_cnt;
	logic        startup_ff;

	always_comb
	begin
		nxt_state   = state_ff;
		nxt_seq_cnt = seq_cnt_ff + 16'h0001;
		case (state_ff)
			SRCS_RUN:
			begin
				nxt_seq_cnt = 16'h0000;
				if (por_lvi)
					nxt_state = SRCS_STARTUP;
				else if (int_src)
					nxt_state = SRCS_DRIVE;
			end
			SRCS_STARTUP:
			begin
				if (seq_cnt_ff == START_LAST)
				begin
					nxt_state   = SRCS_DRIVE;
					nxt_seq_cnt = 16'h0000;
				end
			end
			SRCS_DRIVE:
			begin
				if (seq_cnt_ff == DRIVE_LAST)
				begin
					nxt_state   = SRCS_HOLD;
					nxt_seq_cnt = 16'h0000;
				end
			end
			SRCS_HOLD:
			begin
				if (seq_cnt_ff == HOLD_LAST)
				begin
					nxt_state   = SRCS_RUN;
					nxt_seq_cnt = 16'h0000;
				end
			end
			default:
			begin
				nxt_state   = SRCS_RUN;
				nxt_seq_cnt = 16'h0000;
			end
		endcase
	end

	// Power-up starts in the startup phase, as a power-on event.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff   <= SRCS_STARTUP;
			seq_cnt_ff <= 16'h0000;
		end
		else
		begin
			state_ff   <= nxt_state;
			seq_cnt_ff <= nxt_seq_cnt;
		end
	end

	// Remembers that the current sequence came from power-on or low voltage.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			startup_ff <= 1'b1;
		else if (state_ff == SRCS_RUN)
			startup_ff <= por_lvi;
	end

	// ==========================================================
	// Reset pin and internal reset
	logic pin_low;
	assign pin_low = !pin_s2_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			reset_pin_oe  <= 1'b1;
			reset_pin_out <= 1'b0;
		end
		else
		begin
			reset_pin_oe  <= (nxt_state == SRCS_STARTUP) || (nxt_state == SRCS_DRIVE);
			reset_pin_out <= 1'b0;
		end
	end

	// internal reset
	// Pin low halts processing as well as every sequenced phase.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			internal_reset <= 1'b1;
		else
			internal_reset <= (nxt_state != SRCS_RUN) || pin_low;
	end

	// ==========================================================
	// Pin low-time counter for the pin cause flag
	logic [15:0] pin_cnt_ff;
	logic        pin_event;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin_cnt_ff <= 16'h0000;
		else if (!pin_low)
			pin_cnt_ff <= 16'h0000;
		else if (pin_cnt_ff != 16'hffff)
			pin_cnt_ff <= pin_cnt_ff + 16'h0001;
	end

	assign pin_event = pin_low &&
		(pin_cnt_ff == (startup_ff ? PORLVI_PIN : PIN_LAST));

	// ==========================================================
	// Prescaler on the falling edge of the oscillator clock
	logic clr_presc_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			clr_presc_ff <= 1'b1;
		else
			clr_presc_ff <= (state_ff == SRCS_RUN) && int_src;
	end

	always_ff @(negedge pclk or negedge presetn)
	begin
		if (!presetn)
			prescaler <= '0;
		else if (clr_presc_ff)
			prescaler <= '0;
		else
			prescaler <= prescaler + 1'b1;
	end

	// ==========================================================
	// Clock enables
	logic [1:0] bus_div_ff;
	logic       wait_ff;
	logic       pll_sel_ff;
	logic       monitor_ff;
	logic       clk_src;
	logic       clk_src_s1_ff;
	logic       clk_src_s2_ff;
	logic       clk_src_d_ff;

	assign clk_src = pll_sel_ff ? pll_out_clock : clock_gen_output;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clk_src_s1_ff <= 1'b0;
			clk_src_s2_ff <= 1'b0;
			clk_src_d_ff  <= 1'b0;
		end
		else
		begin
			clk_src_s1_ff <= clk_src;
			clk_src_s2_ff <= clk_src_s1_ff;
			clk_src_d_ff  <= clk_src_s2_ff;
		end
	end

	// divide
	// Rising source edges toggle a divide-by-two, giving one quarter overall.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bus_div_ff <= 2'b00;
		else if (internal_reset)
			bus_div_ff <= 2'b00;
		else if (clk_src_s2_ff && !clk_src_d_ff)
			bus_div_ff <= bus_div_ff + 2'(BUS_DIVIDE - 1);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			internal_bus_clocks <= 1'b0;
			cpu_clock_en        <= 1'b0;
			periph_clock_en     <= 1'b0;
		end
		else
		begin
			internal_bus_clocks <= (nxt_state != SRCS_STARTUP) && bus_div_ff[0];
			cpu_clock_en        <= (nxt_state != SRCS_STARTUP) && !wait_ff;
			periph_clock_en     <= nxt_state != SRCS_STARTUP;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			reset_vector <= VEC_USER;
		else
			reset_vector <= monitor_ff ? VEC_MONITOR : VEC_USER;
	end

	// ==========================================================
	// APB registers
	logic       wr_en;
	logic       rd_en;
	logic [7:0] cause_ff;
	logic       bsw_ff;

	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && !penable && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
		hit = (a == ofs);
	endfunction

	// cause flags
	// Power-on clears every other cause; other events from run replace the flags with their own bits, a later pin event adds its bit.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cause_ff <= RST_RESET_CAUSE;
		else if (req_s.power_on)
			cause_ff <= RST_RESET_CAUSE;
		else if (state_ff == SRCS_RUN && (int_src || pin_event))
		begin
			cause_ff <= RST_ZERO;
			cause_ff[BIT_PIN]  <= pin_event;
			cause_ff[BIT_COP]  <= req_s.watchdog;
			cause_ff[BIT_BAD_OPCODE_FLAG] <= req_s.bad_opcode;
			cause_ff[BIT_BAD_FETCH_ADDRESS_FLAG] <= req_s.bad_fetch;
			cause_ff[BIT_LVI]  <= req_s.low_voltage;
		end
		else if (pin_event)
			cause_ff[BIT_PIN] <= 1'b1;
	end

	// break flag clear
	// A set in the same cycle as a clearing write wins.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bsw_ff <= 1'b0;
		else if (bsw_s2_ff)
			bsw_ff <= 1'b1;
		else if (wr_en && hit(paddr, OFS_BREAK_STATUS) && !pwdata[BIT_BREAK_STOP_WAIT])
			bsw_ff <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			break_flag_clear_enable <= 1'b0;
			pll_sel_ff              <= 1'b0;
			monitor_ff              <= 1'b0;
			wait_ff                 <= 1'b0;
		end
		else if (internal_reset)
		begin
			break_flag_clear_enable <= 1'b0;
			pll_sel_ff              <= 1'b0;
			monitor_ff              <= 1'b0;
			wait_ff                 <= 1'b0;
		end
		else if (wr_en && hit(paddr, OFS_BREAK_FLAG_CONTROL))
			break_flag_clear_enable <= pwdata[BIT_CLR_ENABLE];
		else if (wr_en && hit(paddr, OFS_SEQ_CONTROL))
		begin
			pll_sel_ff <= pwdata[BIT_CTL_PLL_SEL];
			monitor_ff <= pwdata[BIT_CTL_MONITOR];
			wait_ff    <= pwdata[BIT_CTL_WAIT];
		end
	end

	// Read data registered in the setup phase, valid in the access phase.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_en)
		begin
			prdata <= 32'h0000_0000;
			if (hit(paddr, OFS_BREAK_STATUS))
				prdata[BIT_BREAK_STOP_WAIT] <= bsw_ff;
			else if (hit(paddr, OFS_RESET_CAUSE_STATUS))
				prdata[7:0] <= cause_ff;
			else if (hit(paddr, OFS_BREAK_FLAG_CONTROL))
				prdata[BIT_CLR_ENABLE] <= break_flag_clear_enable;
			else if (hit(paddr, OFS_SEQ_CONTROL))
				prdata[2:0] <= {wait_ff, monitor_ff, pll_sel_ff};
		end
	end

endmodule
`default_nettype wire

// ==== hw/srcs_pkg.sv ====
// Package for the reset and bus-clock sequencer: register map, field layout, timing counts.
// Assumes an APB master with 32-bit data and the 250 MHz pclk.
`default_nettype none
package srcs_pkg;

	// ==========================================================
	// Register map
	localparam logic [15:0] OFS_BREAK_STATUS       = 16'hfe00;
	localparam logic [15:0] OFS_RESET_CAUSE_STATUS = 16'hfe01;
	localparam logic [15:0] OFS_BREAK_FLAG_CONTROL = 16'hfe03;
	localparam logic [15:0] OFS_SEQ_CONTROL        = 16'hfe04;

	// ==========================================================
	// Field positions
	localparam int BIT_BREAK_STOP_WAIT = 1;
	localparam int BIT_CLR_ENABLE      = 7;
	localparam int BIT_POR             = 7;
	localparam int BIT_PIN             = 6;
	localparam int BIT_COP             = 5;
	localparam int BIT_BAD_OPCODE_FLAG            = 4;
	localparam int BIT_BAD_FETCH_ADDRESS_FLAG            = 3;
	localparam int BIT_LVI             = 1;
	localparam int BIT_CTL_PLL_SEL     = 0;
	localparam int BIT_CTL_MONITOR     = 1;
	localparam int BIT_CTL_WAIT        = 2;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_RESET_CAUSE = 8'h80;
	localparam logic [7:0] RST_ZERO        = 8'h00;

	// ==========================================================
	// Reset vectors
	localparam logic [15:0] VEC_USER    = 16'hfffe;
	localparam logic [15:0] VEC_MONITOR = 16'hfefe;

	// ==========================================================
	// Timing counts in oscillator clock cycles
	localparam int STARTUP_CYCLES   = 4096;
	localparam int PIN_DRIVE_CYCLES = 32;
	localparam int INTERNAL_RESET_HOLD_CYCLES = 32;
	localparam int PIN_FLAG_CYCLES  = 67;
	localparam int PORLVI_PIN_CYCLES = 4163;
	localparam int PRESCALER_WIDTH  = 13;
	localparam int BUS_DIVIDE       = 2;

	typedef enum logic [1:0] {
		SRCS_RUN,
		SRCS_STARTUP,
		SRCS_DRIVE,
		SRCS_HOLD
	} srcs_state_t;

	typedef struct packed {
		logic power_on;
		logic low_voltage;
		logic watchdog;
		logic bad_opcode;
		logic bad_fetch;
	} srcs_req_t;

endpackage
`default_nettype wire

// ==== verif/srcs_seq_sva.sv ====
// Port checker for the reset sequencer.
// Assumes the package is compiled and the bind below finds the design.
`default_nettype none
module srcs_seq_sva
	import srcs_pkg::*;
#(
	parameter int STARTUP_LEN = STARTUP_CYCLES
)(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        reset_pin_in,
	input wire logic        reset_pin_oe,
	input wire logic        internal_reset,
	input wire logic [15:0] reset_vector,
	input wire logic        cpu_clock_en,
	input wire logic        periph_clock_en,
	input wire logic [12:0] prescaler
);
	// ==========================================================
	// Helper counters
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] drv_ff;
	logic [7:0]  hld_ff;
	logic        seen_ff;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			drv_ff <= 16'h0000;
			hld_ff <= 8'h00;
			seen_ff <= 1'b1;
		end
		else
		begin
			drv_ff <= reset_pin_oe ? drv_ff + 16'h0001 : 16'h0000;
			hld_ff <= (internal_reset && !reset_pin_oe) ? hld_ff + 8'h01 : 8'h00;
			seen_ff <= reset_pin_oe || (seen_ff && internal_reset);
		end
	end
	a_drive_in_reset: assert property (reset_pin_oe |-> internal_reset)
		else $error("pin driven outside internal reset");
	a_drive_len: assert property ($fell(reset_pin_oe) |-> drv_ff == 16'(PIN_DRIVE_CYCLES)
		|| drv_ff == 16'(STARTUP_LEN + PIN_DRIVE_CYCLES))
		else $error("pin drive length wrong");
	a_hold_len: assert property ($fell(internal_reset) && seen_ff
		|-> hld_ff == 8'(INTERNAL_RESET_HOLD_CYCLES))
		else $error("internal reset hold length wrong");
	a_clocks_held: assert property ((!periph_clock_en |-> reset_pin_oe) and
		($rose(periph_clock_en) |-> reset_pin_oe && drv_ff == 16'(STARTUP_LEN)))
		else $error("clocks running during startup");
	a_vector_legal: assert property (reset_vector == VEC_USER || reset_vector == VEC_MONITOR)
		else $error("reset vector illegal");
	a_pin_halts: assert property (!reset_pin_in |-> ##[0:4] internal_reset)
		else $error("low pin did not halt");
	a_wait_periph: assert property (cpu_clock_en |-> periph_clock_en)
		else $error("cpu clock without peripheral clock");
	a_presc_step: assert property (!internal_reset && !$past(internal_reset)
		|-> prescaler == $past(prescaler) + 13'h0001)
		else $error("prescaler did not advance by one");
endmodule
bind srcs_sequencer srcs_seq_sva #(.STARTUP_LEN(STARTUP_LEN)) u_sva (.pclk, .presetn,
	.reset_pin_in, .reset_pin_oe, .internal_reset, .reset_vector, .cpu_clock_en,
	.periph_clock_en, .prescaler);
`default_nettype wire

// ==== verif/srcs_pin_party.sv ====
// External party on the reset pin, with the board pull-up.
// Assumes go is a one-cycle pulse that loads the low length.
`default_nettype none
module srcs_pin_party
(
	input  wire logic       pclk,
	input  wire logic [7:0] low_len,
	input  wire logic       go,
	input  wire logic       dev_oe,
	output logic            pin
);
	logic [7:0] cnt_ff = 8'h00;
	always_ff @(posedge pclk)
	begin
		if (go)
			cnt_ff <= low_len;
		else if (cnt_ff != 8'h00)
			cnt_ff <= cnt_ff - 8'h01;
	end
	// The pull-up wins once nobody pulls low.
	assign pin = !(dev_oe || cnt_ff != 8'h00);
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench of the reset sequencer.
// Assumes checker and pin party model are compiled first.
`default_nettype none
module tb_top import srcs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, go;
	logic        pll_out_clock, clock_gen_output, break_stop_wait_set, reset_pin_in;
	logic        reset_pin_out, reset_pin_oe, internal_reset, internal_bus_clocks;
	logic        cpu_clock_en, periph_clock_en, break_flag_clear_enable;
	logic [15:0] paddr, reset_vector;
	logic [31:0] pwdata, prdata, rd, c;
	logic [12:0] prescaler, p0;
	logic [7:0]  len;
	srcs_req_t   reset_req;
	int          error_cnt, check_count, seed, n, cyc, c0, nb;
	logic        lb;
	srcs_sequencer #(.STARTUP_LEN(16)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .pll_out_clock, .clock_gen_output,
		.reset_req, .break_stop_wait_set, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
		.internal_reset, .reset_vector, .internal_bus_clocks, .cpu_clock_en,
		.periph_clock_en, .prescaler, .break_flag_clear_enable);
	srcs_pin_party pty (.pclk, .low_len(len), .go, .dev_oe(reset_pin_oe), .pin(reset_pin_in));
	always #2 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;
	always @(posedge pclk) clock_gen_output <= ~clock_gen_output;
	always @(posedge pclk) pll_out_clock <= pll_out_clock ^ clock_gen_output;
	// ==========================================================
	// Tasks
	function automatic int fbit(int i);
		return i == 0 ? BIT_BAD_FETCH_ADDRESS_FLAG : i == 1 ? BIT_BAD_OPCODE_FLAG : i == 2 ? BIT_COP : i == 3 ? BIT_LVI : BIT_POR;
	endfunction
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(logic w, logic [15:0] a, logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rdchk(string nm, logic [15:0] a, logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd);
	endtask
	task automatic settle();
		repeat (4) @(posedge pclk);
		n = 0;
		while (internal_reset !== 1'b0 && n < 9000)
		begin
			@(posedge pclk);
			n++;
		end
		@(posedge pclk);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ==========================================================
	// Sequence
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, go, break_stop_wait_set} = 7'h00;
		{pll_out_clock, clock_gen_output, paddr, pwdata, len, reset_req} = '0;
		{error_cnt, check_count, cyc, seed} = {32'd0, 32'd0, 32'd0, 32'd4};
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		settle();
		rdchk("cause", OFS_RESET_CAUSE_STATUS, 32'h0000_0080);
		rdchk("unmapped", 16'hfe02, 32'h0000_0000);
		break_stop_wait_set <= 1'b1;
		@(posedge pclk);
		break_stop_wait_set <= 1'b0;
		repeat (4) @(posedge pclk);
		rdchk("bsw", OFS_BREAK_STATUS, 32'h0000_0002);
		apb(1'b1, OFS_BREAK_STATUS, 32'h0000_0000);
		rdchk("bsw", OFS_BREAK_STATUS, 32'h0000_0000);
		apb(1'b1, OFS_BREAK_FLAG_CONTROL, 32'h0000_0080);
		rdchk("break_flag_clear_enable", OFS_BREAK_FLAG_CONTROL, 32'h0000_0080);
		apb(1'b1, OFS_SEQ_CONTROL, 32'h0000_0006);
		repeat (2) @(posedge pclk);
		chk("vector", 32'(VEC_MONITOR), 32'(reset_vector));
		nb = 0;
		lb = internal_bus_clocks;
		repeat (16)
		begin
			@(posedge pclk);
			if (internal_bus_clocks && !lb)
				nb++;
			lb = internal_bus_clocks;
		end
		chk("busclk", 32'd4, 32'(nb));
		chk("cpu", 32'h0000_0000, 32'(cpu_clock_en));
		chk("periph", 32'h0000_0001, 32'(periph_clock_en));
		$display("registers done");
		for (int i = 0; i < 5; i++)
		begin
			reset_req <= srcs_req_t'(5'h01 << i);
			repeat (2 + {$random(seed)} % 4) @(posedge pclk);
			reset_req <= '0;
			settle();
			chk("presc", 32'h0000_0001, 32'(prescaler < 13'h0100));
			apb(1'b0, OFS_RESET_CAUSE_STATUS, 32'h0000_0000);
			chk("cause", 32'h0000_0001 << fbit(i), rd & (i == 4 ? 32'h0000_00ff :
				32'h0000_0080 | 32'h0000_0001 << fbit(i)));
		end
		chk("vector", 32'(VEC_USER), 32'(reset_vector));
		chk("break_flag_clear_enable", 32'h0000_0000, 32'(break_flag_clear_enable));
		$display("internal resets done");
		for (int i = 0; i < 2; i++)
		begin
			n = i ? 80 + {$random(seed)} % 40 : 40 + {$random(seed)} % 15;
			p0 = prescaler;
			c0 = cyc;
			len <= 8'(n);
			go <= 1'b1;
			@(posedge pclk);
			go <= 1'b0;
			repeat (n + 4) @(posedge pclk);
			settle();
			chk("presc", 32'(13'(p0 + 13'(cyc - c0))), 32'(prescaler));
			apb(1'b0, OFS_RESET_CAUSE_STATUS, 32'h0000_0000);
			chk("pin", 32'(i), 32'(rd[BIT_PIN]));
		end
		c = rd;
		apb(1'b1, OFS_RESET_CAUSE_STATUS, 32'h0000_00ff);
		rdchk("cause", OFS_RESET_CAUSE_STATUS, c);
		$display("pin resets done");
		close_out();
	end
	initial
	begin
		#50000;
		error_cnt++;
		close_out();
	end
endmodule
`default_nettype wire
